// ===== rtl/atr_pkg.sv
// Types shared by the angle readout block
package atr_pkg;
	typedef enum logic [2:0] {
		ATR_K_IDLE,
		ATR_K_1,
		ATR_K_2,
		ATR_K_3,
		ATR_K_4,
		ATR_K_OPEN
	} atr_key_t;
endpackage

// ===== rtl/atr_readout.sv
// Angle, turns delta and access key readout registers
`timescale 1ns/1ps
`default_nettype none
`include "atr_regs.svh"
module atr_readout
	import atr_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic REG_WR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic [11:0] PLL_ANGLE,
	input wire logic [11:0] HYS_ANGLE,
	input wire logic TURNS_HYSTERESIS_CFG,
	input wire logic [14:0] FINE_ANGLE,
	input wire logic [11:0] CROSSING_ANGLE,
	input wire logic [20:0] TURNS_DELTA,
	input wire logic TURNS_45_MODE,
	input wire logic LOW_POWER,
	input wire logic UV_ANALOG,
	input wire logic UV_DIGITAL,
	input wire logic UV_ANALOG_MASK,
	input wire logic UV_DIGITAL_MASK,
	input wire logic [11:0] FAULT_EVENTS,
	input wire logic [11:0] FAULT_MASK,
	input wire logic [11:0] CAUTION_EVENTS,
	input wire logic [11:0] CAUTION_MASK,
	output logic TURNS_FROM_CROSSING,
	output logic UNLOCKED,
	output logic ERROR_SUMMARY
);

	// Odd parity over a word whose bit 12 is still zero
	function automatic logic [15:0] with_parity(input logic [15:0] w);
		logic [15:0] r;
		r = w;
		r[`ATR_PARITY_BIT] = ~(^w);
		return r;
	endfunction

	logic [`ATR_FLAG_W-1:0] fault_latched;
	logic [`ATR_FLAG_W-1:0] caution_latched;
	logic [10:0] offset_snap;
	logic offset_held;
	logic [11:0] lower_snap;
	logic lower_held;
	logic turns_source_select;
	atr_key_t key_state;
	atr_key_t next_key_state;

	// Address decode
	wire rd_turns = REG_RD && REG_ADDR == `ATR_TURNS_ADDR;
	wire rd_offset = REG_RD && REG_ADDR == `ATR_OFFSET_ADDR;
	wire rd_upper = REG_RD && REG_ADDR == `ATR_UPPER_ADDR;
	wire rd_lower = REG_RD && REG_ADDR == `ATR_LOWER_ADDR;
	wire wr_fault = REG_WR && REG_ADDR == `ATR_FAULT_ADDR;
	wire wr_caution = REG_WR && REG_ADDR == `ATR_CAUTION_ADDR;
	wire wr_upper = REG_WR && REG_ADDR == `ATR_UPPER_ADDR;
	wire wr_key = REG_WR && REG_ADDR == `ATR_KEY_ADDR;
	wire [7:0] key_byte = REG_WDATA[15:8];

	// Live status bits shared by several words
	wire undervoltage_flag = (UV_ANALOG && !UV_ANALOG_MASK) ||
		(UV_DIGITAL && !UV_DIGITAL_MASK);
	wire error_summary_flag = |(fault_latched & ~FAULT_MASK) ||
		|(caution_latched & ~CAUTION_MASK);
	wire unlocked_flag = key_state == ATR_K_OPEN;

	// Offset: 45-degree mode keeps only 9 bits, the rest read zero
	wire [10:0] offset_live = TURNS_45_MODE ?
		{2'h0, TURNS_DELTA[8:0]} : TURNS_DELTA[10:0];
	wire [10:0] offset_value = offset_held ? offset_snap : offset_live;
	wire [11:0] upper_field = {{3{TURNS_DELTA[20]}},
		TURNS_DELTA[20:12]};
	wire [11:0] lower_value = lower_held ? lower_snap :
		TURNS_DELTA[11:0];
	wire [11:0] processed_angle = PLL_ANGLE;
	wire [11:0] turn_angle = TURNS_HYSTERESIS_CFG ? HYS_ANGLE :
		PLL_ANGLE;

	// Readout words before parity; undefined bits stay zero
	wire [15:0] w_offset = {1'b0, offset_held, 3'h0, offset_value};
	wire [15:0] w_angle = {1'b0, error_summary_flag, undervoltage_flag,
		1'b0, processed_angle};
	wire [15:0] w_cross = {1'b0, error_summary_flag, undervoltage_flag,
		1'b0, CROSSING_ANGLE};
	wire [15:0] w_upper = {1'b0, error_summary_flag, turns_source_select,
		1'b0, upper_field};
	wire [15:0] w_lower = {1'b0, error_summary_flag, lower_held,
		1'b0, lower_value};
	wire [15:0] w_turn = {1'b0, error_summary_flag, undervoltage_flag,
		1'b0, turn_angle};
	wire [15:0] w_key = {8'h00, 7'h00, unlocked_flag};

	// Read multiplexer; fine, key, fault and caution words carry no parity bit
	wire [15:0] read_mux =
		REG_ADDR == `ATR_OFFSET_ADDR ? with_parity(w_offset) :
		REG_ADDR == `ATR_ANGLE_ADDR ? with_parity(w_angle) :
		REG_ADDR == `ATR_FINE_ADDR ? {1'b0, FINE_ANGLE} :
		REG_ADDR == `ATR_CROSS_ADDR ? with_parity(w_cross) :
		REG_ADDR == `ATR_UPPER_ADDR ? with_parity(w_upper) :
		REG_ADDR == `ATR_LOWER_ADDR ? with_parity(w_lower) :
		REG_ADDR == `ATR_TURN_ADDR ? with_parity(w_turn) :
		REG_ADDR == `ATR_KEY_ADDR ? w_key :
		REG_ADDR == `ATR_FAULT_ADDR ? {4'h0, fault_latched} :
		REG_ADDR == `ATR_CAUTION_ADDR ? {4'h0, caution_latched} :
		16'h0000;

	// Read answer, one cycle after the strobe
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= 16'h0000;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			REG_RDATA <= REG_RD ? read_mux : 16'h0000;
		end
	end

	// Latched faults: a new event wins over a clear in the same cycle
	wire [11:0] next_fault = (fault_latched &
		~(wr_fault ? REG_WDATA[11:0] : 12'h000)) | FAULT_EVENTS;
	wire [11:0] next_caution = (caution_latched &
		~(wr_caution ? REG_WDATA[11:0] : 12'h000)) | CAUTION_EVENTS;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			fault_latched <= 12'h000;
			caution_latched <= 12'h000;
		end else begin
			fault_latched <= next_fault;
			caution_latched <= next_caution;
		end
	end

	// Offset snapshot taken when the turns word is read
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			offset_snap <= 11'h000;
			offset_held <= 1'b0;
		end else if (rd_turns) begin
			offset_snap <= offset_live;
			offset_held <= 1'b1;
		end else if (rd_offset) begin
			offset_held <= 1'b0;
		end
	end

	// Lower delta frozen by an upper read so both halves match;
	// a host that reads lower first gets the live, unheld value
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			lower_snap <= 12'h000;
			lower_held <= 1'b0;
		end else if (rd_upper) begin
			lower_snap <= TURNS_DELTA[11:0];
			lower_held <= 1'b1;
		end else if (rd_lower) begin
			lower_held <= 1'b0;
		end
	end

	// Turns source select; resets to the recommended PLL source
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			turns_source_select <= `ATR_SEL_RESET;
		end else if (wr_upper) begin
			turns_source_select <= REG_WDATA[`ATR_SEL_BIT];
		end
	end

	// Key sequence; a wrong byte restarts, 0x00 counting as first
	wire restart = key_byte == `ATR_KEY0;
	always_comb begin
		next_key_state = key_state;
		if (wr_key) begin
			case (key_state)
				ATR_K_IDLE: next_key_state = restart ? ATR_K_1 : ATR_K_IDLE;
				ATR_K_1: next_key_state = key_byte == `ATR_KEY1 ? ATR_K_2 :
					restart ? ATR_K_1 : ATR_K_IDLE;
				ATR_K_2: next_key_state = key_byte == `ATR_KEY2 ? ATR_K_3 :
					restart ? ATR_K_1 : ATR_K_IDLE;
				ATR_K_3: next_key_state = key_byte == `ATR_KEY3 ? ATR_K_4 :
					restart ? ATR_K_1 : ATR_K_IDLE;
				ATR_K_4: next_key_state = key_byte == `ATR_KEY4 ? ATR_K_OPEN :
					restart ? ATR_K_1 : ATR_K_IDLE;
				ATR_K_OPEN: next_key_state = ATR_K_OPEN; // Held until reset
				default: next_key_state = ATR_K_IDLE;
			endcase
		end
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			key_state <= ATR_K_IDLE;
		end else begin
			key_state <= next_key_state;
		end
	end

	// Registered status outputs
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			TURNS_FROM_CROSSING <= 1'b1;
			UNLOCKED <= 1'b0;
			ERROR_SUMMARY <= 1'b0;
		end else begin
			TURNS_FROM_CROSSING <= LOW_POWER || !turns_source_select;
			UNLOCKED <= unlocked_flag;
			ERROR_SUMMARY <= error_summary_flag;
		end
	end

	// Checks
	default clocking chk_cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	logic [7:0] last_addr;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			last_addr <= 8'h00;
		end else if (REG_RD) begin
			last_addr <= REG_ADDR;
		end
	end
	wire par_word = REG_RVALID && last_addr != `ATR_FINE_ADDR &&
		last_addr != `ATR_KEY_ADDR && last_addr != `ATR_FAULT_ADDR &&
		last_addr != `ATR_CAUTION_ADDR && last_addr[7:4] >= 4'h2 &&
		last_addr <= `ATR_TURN_ADDR && last_addr >= `ATR_OFFSET_ADDR;

	parity_odd_a: assert property (par_word |-> ^REG_RDATA)
		else $error("readout word parity not odd");
	key_zero_a: assert property (REG_RD && REG_ADDR == `ATR_KEY_ADDR
		|=> REG_RDATA[15:1] == 15'h0000 && REG_RDATA[0] == UNLOCKED)
		else $error("key word readback wrong");
	unlock_seq_a: assert property (wr_key && key_byte == `ATR_KEY0 ##1
		wr_key && key_byte == `ATR_KEY1 ##1 wr_key && key_byte == `ATR_KEY2
		##1 wr_key && key_byte == `ATR_KEY3 ##1 wr_key &&
		key_byte == `ATR_KEY4 |-> ##2 UNLOCKED)
		else $error("key sequence did not unlock");
	lower_freeze_a: assert property (rd_upper ##1 rd_lower |=>
		REG_RDATA[`ATR_HELD1_BIT] && REG_RDATA[11:0] ==
		$past(TURNS_DELTA[11:0], 2))
		else $error("lower delta not frozen by upper read");
	lower_clear_a: assert property (rd_lower |=> !lower_held)
		else $error("lower held flag not cleared");
	offset_flag_a: assert property (rd_turns ##1 rd_offset |=>
		REG_RDATA[`ATR_HELD_BIT] ##1 !offset_held)
		else $error("offset held flag wrong");
	upper_sign_a: assert property (rd_upper |=> REG_RDATA[11:0] ==
		{{3{$past(TURNS_DELTA[20])}}, $past(TURNS_DELTA[20:12])})
		else $error("upper delta not sign extended");
	uv_flag_a: assert property (REG_RD && REG_ADDR == `ATR_ANGLE_ADDR |=>
		REG_RDATA[`ATR_UV_BIT] == $past(undervoltage_flag) &&
		REG_RDATA[11:0] == $past(PLL_ANGLE))
		else $error("angle word flag or value wrong");
	fault_hold_a: assert property (|FAULT_EVENTS |=>
		(fault_latched & $past(FAULT_EVENTS)) == $past(FAULT_EVENTS))
		else $error("fault event not latched");
	src_sel_a: assert property (LOW_POWER |=> TURNS_FROM_CROSSING)
		else $error("low power not using crossing angle");
	offset45_a: assert property (TURNS_45_MODE && !offset_held && rd_offset
		|=> REG_RDATA[10:9] == 2'h0)
		else $error("offset wider than 9 bits in 45 mode");
	fine_a: assert property (REG_RD && REG_ADDR == `ATR_FINE_ADDR |=>
		REG_RDATA == {1'b0, $past(FINE_ANGLE)})
		else $error("fine angle word wrong");

	// Helper decodes for the word-level checks
	wire ef_word = REG_ADDR == `ATR_ANGLE_ADDR ||
		REG_ADDR == `ATR_CROSS_ADDR || REG_ADDR == `ATR_UPPER_ADDR ||
		REG_ADDR == `ATR_LOWER_ADDR || REG_ADDR == `ATR_TURN_ADDR;
	wire mapped = ef_word || REG_ADDR == `ATR_OFFSET_ADDR ||
		REG_ADDR == `ATR_FINE_ADDR || REG_ADDR == `ATR_KEY_ADDR ||
		REG_ADDR == `ATR_FAULT_ADDR || REG_ADDR == `ATR_CAUTION_ADDR;

	// Summary flag must match the live summary at the strobe
	ef_bit_a: assert property (REG_RD && ef_word |=>
		REG_RDATA[`ATR_EF_BIT] == $past(error_summary_flag))
		else $error("summary flag bit wrong");
	// Crossing word carries the raw detector angle and live flag
	cross_word_a: assert property (
		REG_RD && REG_ADDR == `ATR_CROSS_ADDR |=>
		REG_RDATA[11:0] == $past(CROSSING_ANGLE) &&
		REG_RDATA[`ATR_UV_BIT] == $past(undervoltage_flag))
		else $error("crossing word wrong");
	// Turn-source word follows the hysteresis choice
	turn_word_a: assert property (
		REG_RD && REG_ADDR == `ATR_TURN_ADDR |=> REG_RDATA[11:0] ==
		$past(TURNS_HYSTERESIS_CFG ? HYS_ANGLE : PLL_ANGLE))
		else $error("turn-source word wrong");
	// Unheld lower word shows the live low count, flag clear
	lower_live_a: assert property (rd_lower && !lower_held |=>
		REG_RDATA[11:0] == $past(TURNS_DELTA[11:0]) &&
		!REG_RDATA[`ATR_HELD1_BIT])
		else $error("live lower word wrong");
	// Offset in 180-degree mode keeps all 11 low bits
	offset180_a: assert property (
		!TURNS_45_MODE && !offset_held && rd_offset |=>
		REG_RDATA[10:0] == $past(TURNS_DELTA[10:0]))
		else $error("offset wrong in 180 mode");
	// Source select written through bit 13 of the upper word
	sel_write_a: assert property (wr_upper |=>
		turns_source_select == $past(REG_WDATA[`ATR_SEL_BIT]))
		else $error("turns source select not written");
	// Upper word reads back the current source select
	sel_read_a: assert property (
		REG_RD && REG_ADDR == `ATR_UPPER_ADDR |=>
		REG_RDATA[`ATR_SEL_BIT] == $past(turns_source_select))
		else $error("source select readback wrong");
	// Unmapped addresses read zero
	unmapped_zero_a: assert property (REG_RD && !mapped |=>
		REG_RDATA == 16'h0000)
		else $error("unmapped address not zero");
	// Between answers the read bus rests at zero
	rdata_idle_a: assert property (!REG_RVALID |->
		REG_RDATA == 16'h0000)
		else $error("read data not zero when idle");
	// Answer pulse follows every read strobe by one cycle
	rvalid_a: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered");
	// Unlocked state holds until reset
	unlock_hold_a: assert property (UNLOCKED |=> UNLOCKED)
		else $error("unlock lost");
	// Latched bits persist while no clear is written
	fault_keep_a: assert property (!wr_fault |=>
		(fault_latched & $past(fault_latched)) == $past(fault_latched))
		else $error("latched fault lost without clear");
	caution_keep_a: assert property (!wr_caution |=>
		(caution_latched & $past(caution_latched)) ==
		$past(caution_latched))
		else $error("latched caution lost without clear");
	// Summary output is the summary flag one cycle late
	summary_out_a: assert property (
		ERROR_SUMMARY == $past(error_summary_flag))
		else $error("summary output wrong");

	pair_read_c: cover property (rd_upper ##[1:4] rd_lower);
	unlock_c: cover property (!UNLOCKED ##1 UNLOCKED);
	error_c: cover property (REG_RVALID && REG_RDATA[`ATR_EF_BIT]);
	offset_c: cover property (rd_turns ##[1:4] rd_offset);

endmodule
`default_nettype wire

// ===== rtl/atr_regs.svh
// Register offsets, field positions and reset values of the angle readout
// How it works
// - Offset field keeps 11 or 9 delta LSBs
// - Parity bit 12 makes word odd
// - Offset flag set by turns read, cleared
// - Angle fields unsigned 12-bit, 4096 per turn
// - Bit 13 shows masked real-time undervoltage
// - Bit 14 shows any unmasked latched fault or caution
// - Fine word carries unrounded 15-bit angle
// - Crossing angle drives turns in low power
// - Upper delta read freezes lower delta word
// - Upper delta is sign-extended top 9 bits
// - Upper word bit 13 selects turns source
// - Lower delta is low 12 counter bits
// - Lower held flag set, clears on read
// - Turn angle is PLL, optional hysteresis
// - Five key writes unlock; key bits 15:1 read zero
// - Key bit 0 shows unlocked state
// - Faults stay latched until host clears
`ifndef ATR_REGS_SVH
`define ATR_REGS_SVH
`define ATR_TURNS_ADDR 8'h2C
`define ATR_FAULT_ADDR 8'h24
`define ATR_CAUTION_ADDR 8'h26
`define ATR_OFFSET_ADDR 8'h2E
`define ATR_ANGLE_ADDR 8'h30
`define ATR_FINE_ADDR 8'h32
`define ATR_CROSS_ADDR 8'h34
`define ATR_UPPER_ADDR 8'h36
`define ATR_LOWER_ADDR 8'h38
`define ATR_TURN_ADDR 8'h3A
`define ATR_KEY_ADDR 8'h3C
`define ATR_PARITY_BIT 12
`define ATR_UV_BIT 13
`define ATR_SEL_BIT 13
`define ATR_HELD1_BIT 13
`define ATR_EF_BIT 14
`define ATR_HELD_BIT 14
`define ATR_KEY0 8'h00
`define ATR_KEY1 8'h27
`define ATR_KEY2 8'h81
`define ATR_KEY3 8'h1F
`define ATR_KEY4 8'h77
`define ATR_SEL_RESET 1'b1
`define ATR_FLAG_W 12
`endif

// ===== tb/angle_turns_readout_regs_test.sv
// Self-checking bench for the angle and turns readout registers
`timescale 1ns/1ps
`default_nettype none
`include "atr_regs.svh"
`define CHK(g, e) chk(g, e)
module angle_turns_readout_regs_test;
	logic CORE_CLK = 1'b0, RST = 1'b1;
	logic [7:0] REG_ADDR;
	logic REG_RD, REG_WR, REG_RVALID, TURNS_FROM_CROSSING, UNLOCKED, ERROR_SUMMARY;
	logic [15:0] REG_WDATA, REG_RDATA;
	logic [11:0] PLL_ANGLE = 12'hABC, HYS_ANGLE = 12'h5A1;
	logic [11:0] CROSSING_ANGLE = 12'h3E7;
	logic TURNS_HYSTERESIS_CFG = 1'b0, TURNS_45_MODE = 1'b0, LOW_POWER = 1'b0;
	logic [14:0] FINE_ANGLE = 15'h6D5B;
	logic [20:0] TURNS_DELTA = 21'h1F0123;
	logic UV_ANALOG = 1'b0, UV_DIGITAL = 1'b0;
	logic UV_ANALOG_MASK = 1'b0, UV_DIGITAL_MASK = 1'b1;
	logic [11:0] FAULT_EVENTS = 12'h000, FAULT_MASK = 12'h000;
	logic [11:0] CAUTION_EVENTS = 12'h000, CAUTION_MASK = 12'h004;
	int num_errors = 0, comparisons = 0, cycles = 0;
	logic [15:0] keyw [5] = '{16'h0000, 16'h2700, 16'h8100, 16'h1F00,
		16'h7700};
	atr_readout atr_readout_inst (.*);
	atr_host atr_host_inst (.*);
	always #12.5 CORE_CLK = ~CORE_CLK;
	// Cycle ceiling cuts a hung run short
	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Expected word with odd parity placed in bit 12
	function automatic logic [15:0] pw(input logic [15:0] w);
		pw = w;
		pw[12] = ~^w;
	endfunction
	// Read one word, check the answer pulse and the masked value
	task automatic rc(input logic [7:0] a, input logic [15:0] e,
			input logic [15:0] m = 16'hFFFF);
		logic [15:0] d;
		logic v;
		atr_host_inst.rd(a, d, v);
		`CHK({15'h0000, v}, 16'h0001);
		`CHK(d & m, e);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask
	initial begin
		logic [15:0] d1, d2;
		wait_cyc(3);
		RST = 1'b0;
		wait_cyc(2);
		`CHK({14'h0, UNLOCKED, TURNS_FROM_CROSSING}, 16'h0000);
		rc(`ATR_ANGLE_ADDR, pw(16'h0ABC));
		UV_ANALOG = 1'b1;
		rc(`ATR_CROSS_ADDR, pw(16'h23E7));
		UV_ANALOG_MASK = 1'b1;
		UV_DIGITAL = 1'b1;
		rc(`ATR_ANGLE_ADDR, pw(16'h0ABC));
		rc(`ATR_FINE_ADDR, 16'h6D5B);
		// Masked caution stays silent, a fault pulse latches
		CAUTION_EVENTS = 12'h004;
		FAULT_EVENTS = 12'h008;
		wait_cyc(1);
		FAULT_EVENTS = 12'h000;
		CAUTION_EVENTS = 12'h000;
		wait_cyc(3);
		`CHK({15'h0, ERROR_SUMMARY}, 16'h0001);
		rc(`ATR_CROSS_ADDR, pw(16'h43E7));
		atr_host_inst.wr(`ATR_FAULT_ADDR, 16'h0008);
		wait_cyc(3);
		rc(`ATR_ANGLE_ADDR, pw(16'h0ABC));
		// Upper read freezes lower word against a new count
		rc(`ATR_UPPER_ADDR, pw(16'h2FF0));
		TURNS_DELTA = 21'h000456;
		rc(`ATR_LOWER_ADDR, pw(16'h2123));
		rc(`ATR_LOWER_ADDR, pw(16'h0456));
		for (int i = 0; i < 2; i++) begin
			TURNS_45_MODE = i[0];
			rc(`ATR_TURNS_ADDR, 16'h0000, 16'h0000);
			TURNS_DELTA = 21'h000000;
			rc(`ATR_OFFSET_ADDR, pw(i ? 16'h4056 : 16'h4456));
			rc(`ATR_OFFSET_ADDR, 16'h0000, 16'h4000);
			TURNS_DELTA = 21'h000456;
		end
		// Back-to-back pairs: turns then offset, upper then lower
		atr_host_inst.rd2(`ATR_TURNS_ADDR, `ATR_OFFSET_ADDR, d1, d2);
		`CHK(d2, pw(16'h4056));
		atr_host_inst.rd2(`ATR_UPPER_ADDR, `ATR_LOWER_ADDR, d1, d2);
		`CHK(d1, pw(16'h2000));
		`CHK(d2, pw(16'h2456));
		rc(`ATR_TURN_ADDR, pw(16'h0ABC));
		TURNS_HYSTERESIS_CFG = 1'b1;
		rc(`ATR_TURN_ADDR, pw(16'h05A1));
		atr_host_inst.wr(`ATR_UPPER_ADDR, 16'h0000);
		wait_cyc(2);
		`CHK({15'h0, TURNS_FROM_CROSSING}, 16'h0001);
		rc(`ATR_UPPER_ADDR, 16'h0000, 16'h2000);
		atr_host_inst.wr(`ATR_UPPER_ADDR, 16'h2000);
		LOW_POWER = 1'b1;
		wait_cyc(2);
		`CHK({15'h0, TURNS_FROM_CROSSING}, 16'h0001);
		// A wrong byte first, then the full five-write sequence
		atr_host_inst.wr(`ATR_KEY_ADDR, 16'h2700);
		atr_host_inst.wr5(`ATR_KEY_ADDR, keyw);
		wait_cyc(2);
		`CHK({15'h0, UNLOCKED}, 16'h0001);
		rc(`ATR_KEY_ADDR, 16'h0001);
		rc(8'h3E, 16'h0000);
		results();
	end
endmodule
`default_nettype wire

// ===== tb/atr_host.sv
// Host model that drives the register port; strobes last one cycle, or stay high across back-to-back accesses
`timescale 1ns/1ps
`default_nettype none
module atr_host (
	input wire logic CORE_CLK,
	output logic [7:0] REG_ADDR,
	output logic REG_RD,
	output logic REG_WR,
	output logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic REG_RVALID
);
	initial begin
		REG_ADDR = 8'h00;
		REG_RD = 1'b0;
		REG_WR = 1'b0;
		REG_WDATA = 16'h0000;
	end
	// Idle lines flip so a stale address or data never looks valid
	task automatic idle();
		REG_ADDR = ~REG_ADDR;
		REG_WDATA = ~REG_WDATA;
	endtask
	// Callers keep key order and upper-before-lower order
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge CORE_CLK) #1;
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(posedge CORE_CLK) #1;
		REG_WR = 1'b0;
		idle();
	endtask
	// Five writes on consecutive edges, strobe held high throughout
	task automatic wr5(input logic [7:0] a, input logic [15:0] d [5]);
		@(posedge CORE_CLK) #1;
		REG_ADDR = a;
		REG_WR = 1'b1;
		foreach (d[i]) begin
			REG_WDATA = d[i];
			@(posedge CORE_CLK) #1;
		end
		REG_WR = 1'b0;
		idle();
	endtask
	// Two reads back to back; each answer taken while it stands
	task automatic rd2(input logic [7:0] a, input logic [7:0] b,
			output logic [15:0] d, output logic [15:0] e);
		@(posedge CORE_CLK) #1;
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(posedge CORE_CLK) #1;
		REG_ADDR = b;
		d = REG_RDATA;
		@(posedge CORE_CLK) #1;
		REG_RD = 1'b0;
		idle();
		e = REG_RDATA;
	endtask
	// Answer is taken one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [15:0] d,
			output logic v);
		@(posedge CORE_CLK) #1;
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(posedge CORE_CLK) #1;
		REG_RD = 1'b0;
		idle();
		d = REG_RDATA;
		v = REG_RVALID;
	endtask
endmodule
`default_nettype wire
